// ===== core/emc_pkg.sv
package emc_pkg;
  // address widths: 4 MB space is 2M words of 16 bits
  localparam int          ADDR_W        = 22;
  localparam logic [21:0] SPACE_MAX     = 22'h3FFFFF;
  localparam logic [21:0] SPACE_MAX_USB = 22'h0FFFFF;
  // code range and overlay sections
  localparam logic [21:0] CODE_MAX      = 22'h01FFFF;
  localparam int          SECT_LSB      = 14;
  localparam int          SECT_W        = 3;
  localparam int          SECTIONS      = 8;
  localparam logic [21:0] SECT_MASK     = 22'h003FFF;
  // space configuration encodings
  localparam logic [1:0]  CFG_X8        = 2'h0;
  localparam logic [1:0]  CFG_X16_PAIR  = 2'h1;
  localparam logic [1:0]  CFG_X16_ONE   = 2'h2;
  // access timing
  localparam int          CLK_MHZ       = 100;
  localparam int          CYC_NORMAL    = 2;
  localparam int          CYC_SLOW      = 8;
  localparam int          SER_KHZ       = 400;
  localparam int          SER_DIV       = (CLK_MHZ * 1000) / (SER_KHZ * 2);
  localparam int          CNT_W         = 8;
  typedef enum logic [1:0] {
    EMC_IDLE  = 2'b00,
    EMC_SETUP = 2'b01,
    EMC_PULSE = 2'b10,
    EMC_DONE  = 2'b11
  } emc_state_e;
endpackage : emc_pkg

// ===== core/emc_ser_clk.sv
`timescale 1ns/1ps
`default_nettype none
// divider producing serial port bit-rate enable and clock level
module emc_ser_clk #(
  parameter int DIV = emc_pkg::SER_DIV
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  // outputs
  output var  logic ser_clk,
  output var  logic ser_tick
);
  logic [emc_pkg::CNT_W-1:0] cnt;
  wire                       wrap = (cnt == emc_pkg::CNT_W'(DIV - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt      <= '0;
      ser_clk  <= 1'b0;
      ser_tick <= 1'b0;
    end else begin
      cnt      <= wrap ? '0 : cnt + 1'b1;
      ser_clk  <= wrap ? ~ser_clk : ser_clk;
      ser_tick <= wrap & ser_clk;
    end
  end
endmodule : emc_ser_clk
`default_nettype wire

// ===== core/emc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module emc_ctrl #(
  parameter int RAM_TOP_SECT = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // configuration from firmware and strap pins
  input  wire logic        usb_host,
  input  wire logic        code_wide,
  input  wire logic        data_wide,
  input  wire logic [7:0]  overlay_en,
  input  wire logic        clk_fast,
  input  wire logic        boot_serial,
  input  wire logic        config_strap_pins,
  // processor request, byte address
  input  wire logic        req,
  input  wire logic        req_code,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_be,
  input  wire logic [21:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             ack,
  output logic             addr_err,
  output logic [15:0]      rdata,
  // memory pins
  output logic             code_cs_n,
  output logic             data_cs_n,
  output logic [21:1]      mem_addr,
  output logic             byte_select_multi_pin,
  output logic             low_write_strobe,
  output logic             low_byte_lane_enable,
  output logic             mem_read_output_enable,
  output logic [15:0]      mem_dq_o,
  output logic             mem_dq_oe,
  input  wire logic [15:0] mem_dq_i,
  // serial boot port
  output logic             ser_clk,
  output logic             ser_tick
);
  ////////////////////////////////////////////////////////////////////////
  emc_pkg::emc_state_e state;
  emc_pkg::emc_state_e next_state;
  logic [emc_pkg::CNT_W-1:0] cnt;
  logic strap_x16_one;
  logic strap_taken;
  logic cur_code;
  logic cur_write;
  logic [1:0] cur_be;
  logic [21:0] cur_addr;
  logic ser_clk_w;
  logic ser_tick_w;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_taken   <= 1'b0;
      strap_x16_one <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken   <= 1'b1;
      strap_x16_one <= config_strap_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // space limit
  wire [21:0] space_max = usb_host ? emc_pkg::SPACE_MAX_USB : emc_pkg::SPACE_MAX;
  wire        in_range  = (req_addr <= space_max);
  // overlay only in code range; boot ROM is internal so never here
  wire        in_code   = (req_addr <= emc_pkg::CODE_MAX);
  wire [2:0]  sect      = req_addr[emc_pkg::SECT_LSB +: emc_pkg::SECT_W];
  wire        ovl_hit   = req_code && in_code && overlay_en[sect];
  // section s maps to block counted down from RAM top
  wire [7:0]  top_blk   = 8'(RAM_TOP_SECT - 1) - {5'h00, sect};
  wire [21:0] ovl_addr  = {top_blk, req_addr[emc_pkg::SECT_LSB-1:0]} & space_max;
  wire        go_code   = req_code && !ovl_hit;
  wire [21:0] phys_addr = ovl_hit ? ovl_addr : req_addr;

  // width per space; chosen per access
  wire        cur_wide  = cur_code ? code_wide : data_wide;
  wire [1:0]  cur_mode  = !cur_wide ? emc_pkg::CFG_X8 :
                          (strap_x16_one ? emc_pkg::CFG_X16_ONE : emc_pkg::CFG_X16_PAIR);
  // odd byte selects high lane in 8-bit space
  wire        hi_lane   = cur_addr[0];
  wire        in_pulse  = (state == emc_pkg::EMC_PULSE);
  wire        wr_pulse  = in_pulse && cur_write;
  // cycle length set by clock speed setting
  wire [emc_pkg::CNT_W-1:0] cyc_len = clk_fast ? emc_pkg::CNT_W'(emc_pkg::CYC_NORMAL)
                                               : emc_pkg::CNT_W'(emc_pkg::CYC_SLOW);
  wire        cnt_end   = (cnt == cyc_len - 1'b1);

  // strobes active low; multi pin is a low strobe except in 8-bit mode, where it carries address lsb
  wire next_multi = (cur_mode == emc_pkg::CFG_X8)       ? cur_addr[0] :
                    (cur_mode == emc_pkg::CFG_X16_PAIR) ? ~(wr_pulse && cur_be[1]) :
                                                          ~(in_pulse && cur_be[1]);
  wire next_lwr   = (cur_mode == emc_pkg::CFG_X16_PAIR) ? ~(wr_pulse && cur_be[0]) : ~wr_pulse;
  wire next_lbe   = (cur_mode == emc_pkg::CFG_X16_ONE)  ? ~(in_pulse && cur_be[0]) : 1'b1;
  wire next_oe    = ~(in_pulse && !cur_write);
  wire [15:0] x8_wdata = {8'h00, hi_lane ? req_wdata[15:8] : req_wdata[7:0]};
  wire [15:0] x8_rdata = hi_lane ? {mem_dq_i[7:0], 8'h00} : {8'h00, mem_dq_i[7:0]};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      emc_pkg::EMC_IDLE: begin
        if (req && in_range) next_state = emc_pkg::EMC_SETUP;
      end
      emc_pkg::EMC_SETUP: next_state = emc_pkg::EMC_PULSE;
      emc_pkg::EMC_PULSE: begin
        if (cnt_end) next_state = emc_pkg::EMC_DONE;
      end
      emc_pkg::EMC_DONE:  next_state = emc_pkg::EMC_IDLE;
      default:            next_state = emc_pkg::EMC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= emc_pkg::EMC_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= (state == emc_pkg::EMC_PULSE && !cnt_end) ? cnt + 1'b1 : '0;
    end
  end

  // request latch
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_code  <= 1'b0;
      cur_write <= 1'b0;
      cur_be    <= 2'h0;
      cur_addr  <= '0;
    end else if (state == emc_pkg::EMC_IDLE && req && in_range) begin
      cur_code  <= go_code;
      cur_write <= req_write;
      cur_be    <= req_be;
      cur_addr  <= phys_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin outputs; strobes idle high
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      code_cs_n              <= 1'b1;
      data_cs_n              <= 1'b1;
      mem_addr               <= '0;
      byte_select_multi_pin  <= 1'b1;
      low_write_strobe       <= 1'b1;
      low_byte_lane_enable   <= 1'b1;
      mem_read_output_enable <= 1'b1;
      mem_dq_o               <= '0;
      mem_dq_oe              <= 1'b0;
    end else begin
      code_cs_n              <= ~((state != emc_pkg::EMC_IDLE) && cur_code);
      data_cs_n              <= ~((state != emc_pkg::EMC_IDLE) && !cur_code);
      mem_addr               <= cur_addr[21:1];
      byte_select_multi_pin  <= (state == emc_pkg::EMC_IDLE) ? 1'b1 : next_multi;
      low_write_strobe       <= next_lwr;
      low_byte_lane_enable   <= next_lbe;
      mem_read_output_enable <= next_oe;
      mem_dq_o               <= (cur_mode == emc_pkg::CFG_X8) ? x8_wdata : req_wdata;
      mem_dq_oe              <= (state != emc_pkg::EMC_IDLE) && cur_write;
    end
  end

  // answer to processor
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack      <= 1'b0;
      addr_err <= 1'b0;
      rdata    <= '0;
    end else begin
      ack      <= (state == emc_pkg::EMC_DONE);
      addr_err <= (state == emc_pkg::EMC_IDLE) && req && !in_range;
      if (state == emc_pkg::EMC_DONE && !cur_write)
        rdata  <= (cur_mode == emc_pkg::CFG_X8) ? x8_rdata : mem_dq_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial boot port clock
  emc_ser_clk #(
    .DIV (emc_pkg::SER_DIV)
  ) u_ser (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .run      (boot_serial),
    .ser_clk  (ser_clk_w),
    .ser_tick (ser_tick_w)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ser_clk  <= 1'b0;
      ser_tick <= 1'b0;
    end else begin
      ser_clk  <= ser_clk_w;
      ser_tick <= ser_tick_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_no_dual_cs;
    @(posedge mclk) disable iff (sys_rst) !(!code_cs_n && !data_cs_n);
  endproperty
  a_no_dual_cs: assert property (p_no_dual_cs) else $error("both selects low");

  property p_range;
    @(posedge mclk) disable iff (sys_rst)
      (state == emc_pkg::EMC_IDLE && req && usb_host && req_addr > emc_pkg::SPACE_MAX_USB)
      |=> addr_err && state == emc_pkg::EMC_IDLE;
  endproperty
  a_range: assert property (p_range) else $error("out of range access accepted");

  property p_ack_slow;
    @(posedge mclk) disable iff (sys_rst)
      (state == emc_pkg::EMC_SETUP && !clk_fast) |-> ##10 ack;
  endproperty
  // slow cycle length
  // eight strobe cycles, one done cycle, then the registered ack
  a_ack_slow: assert property (p_ack_slow) else $error("slow cycle length wrong");

  property p_x8_lsb;
    @(posedge mclk) disable iff (sys_rst)
      (state == emc_pkg::EMC_PULSE && cur_mode == emc_pkg::CFG_X8)
      |=> byte_select_multi_pin == $past(cur_addr[0]);
  endproperty
  a_x8_lsb: assert property (p_x8_lsb) else $error("multi pin not address lsb");

  property p_oe_read;
    @(posedge mclk) disable iff (sys_rst)
      (state == emc_pkg::EMC_PULSE && cur_write) |=> mem_read_output_enable;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read enable during write");

  property p_pair_hi;
    @(posedge mclk) disable iff (sys_rst)
      (in_pulse && cur_write && cur_mode == emc_pkg::CFG_X16_PAIR && cur_be == 2'h2)
      |=> !byte_select_multi_pin && low_write_strobe;
  endproperty
  a_pair_hi: assert property (p_pair_hi) else $error("paired high write wrong");

  property p_one_lbe;
    @(posedge mclk) disable iff (sys_rst)
      (in_pulse && cur_mode == emc_pkg::CFG_X16_ONE && cur_be[0]) |=> !low_byte_lane_enable;
  endproperty
  a_one_lbe: assert property (p_one_lbe) else $error("lower lane not enabled");

  property p_ovl;
    @(posedge mclk) disable iff (sys_rst)
      (state == emc_pkg::EMC_IDLE && req && in_range && ovl_hit) |=> !cur_code;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overlay fetch not redirected");
endmodule : emc_ctrl
`default_nettype wire

// ===== tb/emc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural x8 / paired x8 / single x16 static memory on one select
module emc_mem_model (
  // setup
  input  wire logic        mclk,
  input  wire logic        wide,
  input  wire logic        one,
  // memory pins
  input  wire logic        cs_n,
  input  wire logic [21:1] addr,
  input  wire logic        bsel,
  input  wire logic        lws,
  input  wire logic        lbe,
  input  wire logic        oe,
  input  wire logic [15:0] dq_o,
  output logic      [15:0] dq_i
);
  logic [7:0]  mem [0:262143];
  logic [15:0] last = 16'h0000;
  logic [17:0] lo;
  logic [17:0] hi;
  logic        lo_ok;
  logic        hi_ok;
  // one organisation for the whole space
  assign lo = wide ? {addr[17:1], 1'b0} : {addr[17:1], bsel};
  assign hi = {addr[17:1], 1'b1};
  assign lo_ok = ~wide | ~one | ~lbe;
  assign hi_ok = wide & (~one | ~bsel);
  // released bus toggles so a stale value never matches
  assign dq_i = (!cs_n && !oe) ? {hi_ok ? mem[hi] : ~last[15:8],
                                  lo_ok ? mem[lo] : ~last[7:0]} : ~last;
  always @(posedge mclk) begin
    last <= dq_i;
    if (!cs_n && !lws && lo_ok) mem[lo] <= dq_o[7:0];
    if (!cs_n && hi_ok && (one ? !lws : !bsel)) mem[hi] <= dq_o[15:8];
  end
endmodule : emc_mem_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        usb_host = 1'b0;
  logic        code_wide = 1'b0;
  logic        data_wide = 1'b1;
  logic [7:0]  overlay_en = 8'h00;
  logic        clk_fast = 1'b1;
  logic        boot_serial = 1'b0;
  logic        strap = 1'b1;
  logic        req = 1'b0;
  logic        req_code = 1'b0;
  logic        req_write = 1'b0;
  logic [1:0]  req_be = 2'h3;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic        ack, addr_err, code_cs_n, data_cs_n, bsel, lws, lbe, oe, dq_oe, ser_tick;
  logic [15:0] rdata, dq_o, dq_i, cdq, ddq;
  logic [21:1] mem_addr;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc_exp = 2;
  int          low_cnt = 0;
  int          n;
  int          hi_n;
  logic        ser_clk;
  always #5 mclk = ~mclk;
  assign dq_i = code_cs_n ? ddq : cdq;
  emc_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .usb_host(usb_host), .code_wide(code_wide),
    .data_wide(data_wide), .overlay_en(overlay_en), .clk_fast(clk_fast),
    .boot_serial(boot_serial), .config_strap_pins(strap), .req(req), .req_code(req_code),
    .req_write(req_write), .req_be(req_be), .req_addr(req_addr), .req_wdata(req_wdata),
    .ack(ack), .addr_err(addr_err), .rdata(rdata), .code_cs_n(code_cs_n),
    .data_cs_n(data_cs_n), .mem_addr(mem_addr), .byte_select_multi_pin(bsel),
    .low_write_strobe(lws), .low_byte_lane_enable(lbe), .mem_read_output_enable(oe),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i), .ser_clk(ser_clk), .ser_tick(ser_tick));
  emc_mem_model code_mem (.mclk(mclk), .wide(code_wide), .one(strap), .cs_n(code_cs_n),
    .addr(mem_addr), .bsel(bsel), .lws(lws), .lbe(lbe), .oe(oe), .dq_o(dq_o), .dq_i(cdq));
  emc_mem_model data_mem (.mclk(mclk), .wide(data_wide), .one(strap), .cs_n(data_cs_n),
    .addr(mem_addr), .bsel(bsel), .lws(lws), .lbe(lbe), .oe(oe), .dq_o(dq_o), .dq_i(ddq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic do_reset(input logic s);
    strap = s;
    sys_rst = 1'b1;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : do_reset
  // k: 0 write, 1 read, 2 refused; m masks the lanes worth comparing
  task automatic acc(input logic c, w, input logic [1:0] be, input logic [21:0] a,
                     input logic [15:0] d, m, input logic [1:0] k);
    @(negedge mclk);
    exp_q.push_back({k, m, d});
    req = 1'b1;
    req_code = c;
    req_write = w;
    req_be = be;
    req_addr = a;
    req_wdata = d;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ack !== 1'b1 && addr_err !== 1'b1 && n < 40);
    check(n < 40, "no answer");
    req = 1'b0;
  endtask : acc
  task automatic word_test();
    logic [15:0] d0;
    logic [15:0] d1;
    logic [15:0] bm;
    logic [21:0] a;
    for (int b = 1; b < 4; b++) begin
      d0 = 16'($urandom());
      d1 = 16'($urandom());
      a = {5'h00, 16'($urandom()), 1'b0};
      bm = {{8{b[1]}}, {8{b[0]}}};
      acc(1'b0, 1'b1, 2'h3, a, d0, 16'hFFFF, 2'h0);
      acc(1'b0, 1'b1, 2'(b), a, d1, 16'hFFFF, 2'h0);
      acc(1'b0, 1'b0, 2'h3, a, (d1 & bm) | (d0 & ~bm), 16'hFFFF, 2'h1);
    end
  endtask : word_test
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (code_cs_n === 1'b0) check(data_cs_n === 1'b1, "both selects low");
    if (oe === 1'b0) check(dq_oe === 1'b0, "bus driven during read");
    if (lws === 1'b0) check(dq_oe === 1'b1, "write data not driven");
    // answers are taken even while a reset is being raised in the same step
    if (ack === 1'b1 || addr_err === 1'b1) begin
      check(exp_q.size() > 0, "answer without request");
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check(addr_err === (e[33:32] == 2'h2), "answer kind");
        if (e[33:32] == 2'h1) begin
          check(((rdata ^ e[15:0]) & e[31:16]) === 16'h0000, "read data");
        end
      end
    end
    if (oe === 1'b0) begin
      low_cnt++;
    end else if (low_cnt != 0) begin
      check(low_cnt == cyc_exp, "strobe width");
      low_cnt = 0;
    end
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    logic [15:0] d;
    logic [21:0] a;
    void'($urandom(32'h1410c629));
    do_reset(1'b1);
    // data SRAM kept 16 bits wide for full rate
    word_test();
    $display("test single x16 done");
    d = 16'($urandom());
    a = {5'h00, 16'($urandom()), 1'b0};
    acc(1'b1, 1'b1, 2'h3, a, d, 16'hFFFF, 2'h0);
    acc(1'b1, 1'b1, 2'h3, a + 22'h1, d, 16'hFFFF, 2'h0);
    acc(1'b1, 1'b0, 2'h3, a, d, 16'h00FF, 2'h1);
    acc(1'b1, 1'b0, 2'h3, a + 22'h1, d, 16'hFF00, 2'h1);
    $display("test byte code space done");
    // let the last strobe width be judged before the setting moves
    @(negedge mclk);
    clk_fast = 1'b0;
    cyc_exp = emc_pkg::CYC_SLOW;
    acc(1'b1, 1'b0, 2'h3, a, d, 16'h00FF, 2'h1);
    @(negedge mclk);
    clk_fast = 1'b1;
    cyc_exp = emc_pkg::CYC_NORMAL;
    $display("test slow cycle done");
    usb_host = 1'b1;
    acc(1'b0, 1'b1, 2'h3, 22'h100000, d, 16'hFFFF, 2'h2);
    acc(1'b0, 1'b1, 2'h3, 22'h0FFFFE, d, 16'hFFFF, 2'h0);
    usb_host = 1'b0;
    acc(1'b0, 1'b1, 2'h3, 22'h3FFFFE, d, 16'hFFFF, 2'h0);
    $display("test range done");
    code_wide = 1'b1;
    for (int s = 0; s < 8; s++) begin
      d = 16'($urandom());
      a = {8'h00, 13'($urandom()), 1'b0};
      // firmware placed in RAM by the host path
      acc(1'b0, 1'b1, 2'h3, 22'((15 - s) * 16384) + a, d, 16'hFFFF, 2'h0);
      overlay_en = 8'(1 << s);
      acc(1'b1, 1'b0, 2'h3, 22'(s * 16384) + a, d, 16'hFFFF, 2'h1);
      overlay_en = 8'h00;
    end
    code_wide = 1'b0;
    $display("test overlay done");
    do_reset(1'b0);
    word_test();
    $display("test paired x8 done");
    boot_serial = 1'b1;
    n = 0;
    while (ser_tick !== 1'b1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    hi_n = 0;
    do begin
      @(negedge mclk);
      n++;
      hi_n += int'(ser_clk === 1'b1);
    end while (ser_tick !== 1'b1 && n < 600);
    check(n == 2 * emc_pkg::SER_DIV, "serial period");
    check(hi_n == emc_pkg::SER_DIV, "serial clock duty");
    $display("test serial clock done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
